// ===== core/sccp_pkg.sv
// Package for the smart-card clock, power and early-answer control slot.
// Assumes a single 40 MHz module clock; shared by the controller and its card clock divider.
package sccp_pkg;

    // Register byte offsets on the APB word map
    localparam logic [7:0] OFS_CTR_CFG = 8'h18;
    localparam logic [7:0] OFS_CLK_CFG = 8'h1C;
    localparam logic [7:0] OFS_PWR_CTRL = 8'h20;
    localparam logic [7:0] OFS_EARLY_THR = 8'h24;
    localparam logic [7:0] OFS_DATA = 8'h3C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h60;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h64;

    // Field positions
    localparam int CTR_DIS_BIT = 4;
    localparam int IRQ_EARLY_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_W = 2;

    // card_clock_config layout, bit 5 down to bit 0
    typedef struct packed {
        logic clock_stop_level;
        logic clock_halt;
        logic sync_card_select;
        logic [2:0] card_clock_divider;
    } sccp_ccr_s;

    // card_session_power_control layout, bit 4 down to bit 0
    typedef struct packed {
        logic sync_reset_drive;
        logic [1:0] rsvd;
        logic warm;
        logic start;
    } sccp_pwr_s;

    // Values after reset
    localparam sccp_ccr_s CCR_RST = 6'h00;
    localparam sccp_pwr_s PWR_RST = 5'h00;
    localparam logic [7:0] THR_RST = 8'h00;
    localparam logic DATA_RST = 1'b1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // Card clock periods that the card reset is held low on activation
    localparam int TICK_W = 16;
    localparam logic [TICK_W-1:0] RST_LOW_TICKS = 16'h0190;

    // Session sequencer states
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_RSTLOW = 4'b0010,
        SEQ_EARLY = 4'b0100,
        SEQ_ACTIVE = 4'b1000
    } sccp_seq_e;

    // Divider code to module clock cycles per card clock period
    function automatic logic [4:0] sccp_div_period(input logic [2:0] code);
        logic [4:0] p;
        case (code)
            3'h0: p = 5'h01;
            3'h1: p = 5'h02;
            3'h2: p = 5'h03;
            3'h3: p = 5'h04;
            3'h4: p = 5'h05;
            3'h5: p = 5'h06;
            3'h6: p = 5'h08;
            default: p = 5'h10;
        endcase
        return p;
    endfunction : sccp_div_period

endpackage : sccp_pkg

// ===== core/sccp_clkdiv.sv
// Card clock divider with glitch-free period changes and stop level.
// Assumes it runs on the module clock; run and divider code come from registers on the same clock.
`timescale 1ns/1ps
module sccp_clkdiv (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic run,
    input wire logic [2:0] div_code,
    input wire logic stop_level,
    output logic card_clk,
    output logic card_tick,
    output logic clk_on
);
    import sccp_pkg::*;

    logic [4:0] cnt_r, cnt_nxt;
    logic [4:0] period_r, period_nxt;
    logic phase_r, phase_nxt;
    logic on_r, on_nxt;
    logic last;

    // Period counter: new codes and stops only take effect at a period boundary
    always_comb begin
        cnt_nxt = cnt_r;
        period_nxt = period_r;
        phase_nxt = phase_r;
        on_nxt = on_r;
        last = (cnt_r == period_r - 5'h01);
        if (!on_r) begin
            cnt_nxt = 5'h00;
            phase_nxt = stop_level;
            if (run) begin
                on_nxt = 1'b1;
                period_nxt = sccp_div_period(div_code);
                phase_nxt = 1'b1;
            end
        end else if (last) begin
            cnt_nxt = 5'h00;
            if (!run) begin
                on_nxt = 1'b0;
                phase_nxt = stop_level;
            end else begin
                period_nxt = sccp_div_period(div_code);
                phase_nxt = 1'b1;
            end
        end else begin
            cnt_nxt = cnt_r + 5'h01;
            phase_nxt = (cnt_nxt < (period_r >> 1));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_r <= 5'h00;
            period_r <= 5'h01;
            phase_r <= 1'b0;
            on_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            period_r <= period_nxt;
            phase_r <= phase_nxt;
            on_r <= on_nxt;
        end
    end

    // Stopped clock shows the stop level bit at once, so a level change never lags a cycle
    // Divide by one passes the module clock; it cannot come from a flip-flop at full rate
    assign card_clk = !on_r ? stop_level : ((period_r == 5'h01) ? sys_clk : phase_r);
    assign card_tick = on_r && (cnt_r == 5'h00);
    assign clk_on = on_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    period_hold_a: assert property ((on_r && !last) |=> $stable(period_r))
        else $error("card clock period changed mid-period");
    // A halt seen at the period end legitimately drops the following tick
    div_five_a: assert property ((card_tick && ce && period_r == 5'h05 && run) |=>
        (!card_tick && ce) [*4] ##1 (card_tick || !$past(run)))
        else $error("divide-by-five period is not five cycles");
    halt_stops_a: assert property ((!run && on_r && ce) [*8] |-> 1'b1 ##[0:16] !on_r)
        else $error("card clock did not stop");
    cover_div_change_c: cover property (on_r && last && period_nxt != period_r);

endmodule : sccp_clkdiv

// ===== core/sccp_ctrl.sv
// Smart-card slot clock, session power and early-answer control with an APB register slave.
// Assumes the character engine, mute timers and FIFO sit outside on the same module clock.
`timescale 1ns/1ps
module sccp_ctrl (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic card_clk,
    output logic card_rst,
    input wire logic card_io_in,
    output logic card_io_out,
    output logic card_io_oe,
    input wire logic uart_io_out,
    input wire logic uart_io_oe,
    input wire logic session_stop,
    output logic io_rx,
    output logic card_tick,
    output logic session_active
);
    import sccp_pkg::*;

    sccp_ccr_s ccr_r, ccr_nxt;
    sccp_pwr_s pwr_r, pwr_nxt;
    logic [7:0] thr_r, thr_nxt;
    logic dis_r, dis_nxt;
    logic data_r, data_nxt;
    logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, stat_set, irq_gate;
    logic [31:0] prdata_r, prdata_nxt;
    logic slverr_r, slverr_nxt, irq_r, irq_nxt;
    logic io_s1_r, io_s2_r, io_prev_r, io_fall;
    logic rst_r, rst_nxt, oe_r, oe_nxt, out_r, out_nxt;
    sccp_seq_e seq_r, seq_nxt;
    logic [TICK_W-1:0] cnt_r, cnt_nxt;
    logic start_clr, warm_clr, setup, wr, mapped;
    logic div_clk, div_on;

    // Card clock generator; only the asynchronous mode runs it
    sccp_clkdiv u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .run(!ccr_r.sync_card_select && !ccr_r.clock_halt),
        .div_code(ccr_r.card_clock_divider),
        .stop_level(ccr_r.clock_stop_level),
        .card_clk(div_clk),
        .card_tick(card_tick),
        .clk_on(div_on)
    );

    // Sync mode clock is a register bit, so software owns every edge
    assign card_clk = ccr_r.sync_card_select ? ccr_r.clock_stop_level : div_clk;

    // I/O pin crosses in through two flops; the edge detector compares the second with a third, delayed copy of it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            io_s1_r <= 1'b1;
            io_s2_r <= 1'b1;
            io_prev_r <= 1'b1;
        end else if (ce) begin
            io_s1_r <= card_io_in;
            io_s2_r <= io_s1_r;
            io_prev_r <= io_s2_r;
        end
    end
    assign io_fall = io_prev_r && !io_s2_r;
    assign io_rx = io_s2_r;

    // Session sequencer: reset low phase, early-answer window, active
    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        stat_set = '0;
        start_clr = 1'b0;
        warm_clr = 1'b0;
        case (seq_r)
            SEQ_IDLE: begin
                warm_clr = pwr_r.warm; // no session to warm-reset
                if (pwr_r.start) begin
                    cnt_nxt = '0;
                    if (ccr_r.sync_card_select) begin
                        seq_nxt = SEQ_ACTIVE;
                        start_clr = 1'b1;
                        stat_set[IRQ_DONE_BIT] = 1'b1;
                    end else begin
                        seq_nxt = SEQ_RSTLOW;
                    end
                end
            end
            SEQ_RSTLOW: begin
                if (card_tick) begin
                    if (cnt_r == RST_LOW_TICKS - 16'h0001) begin
                        seq_nxt = SEQ_EARLY;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
            end
            SEQ_EARLY: begin
                if (io_fall) begin
                    stat_set[IRQ_EARLY_BIT] = (cnt_r < {8'h00, thr_r});
                    stat_set[IRQ_DONE_BIT] = 1'b1;
                    seq_nxt = SEQ_ACTIVE;
                    start_clr = 1'b1;
                    warm_clr = 1'b1;
                end else if (card_tick && cnt_r < {8'h00, thr_r}) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            SEQ_ACTIVE: begin
                if (pwr_r.warm && !ccr_r.sync_card_select) begin
                    seq_nxt = SEQ_RSTLOW;
                    cnt_nxt = '0;
                end
            end
            default: seq_nxt = SEQ_IDLE;
        endcase
        if (session_stop) begin
            seq_nxt = SEQ_IDLE;
            start_clr = 1'b1;
            warm_clr = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seq_r <= SEQ_IDLE;
            cnt_r <= '0;
        end else if (ce) begin
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign session_active = (seq_r != SEQ_IDLE);

    // Pin drivers; registered so the pins never see decode glitches
    always_comb begin
        if (ccr_r.sync_card_select) begin
            rst_nxt = pwr_r.sync_reset_drive;
            out_nxt = 1'b0;
            oe_nxt = !data_r;
        end else begin
            rst_nxt = (seq_r == SEQ_EARLY) || (seq_r == SEQ_ACTIVE);
            out_nxt = uart_io_out;
            oe_nxt = uart_io_oe;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rst_r <= 1'b0;
            out_r <= 1'b1;
            oe_r <= 1'b0;
        end else if (ce) begin
            rst_r <= rst_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end
    assign card_rst = rst_r;
    assign card_io_out = out_r;
    assign card_io_oe = oe_r;

    // APB decode: read data is captured in setup so access answers with zero wait
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign mapped = (paddr == OFS_CTR_CFG) || (paddr == OFS_CLK_CFG) || (paddr == OFS_PWR_CTRL) ||
                    (paddr == OFS_EARLY_THR) || (paddr == OFS_DATA) || (paddr == OFS_IRQ_STAT) ||
                    (paddr == OFS_IRQ_MASK);

    // Register file next state; status set wins over a write-one clear
    always_comb begin
        ccr_nxt = ccr_r;
        pwr_nxt = pwr_r;
        thr_nxt = thr_r;
        dis_nxt = dis_r;
        data_nxt = data_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        prdata_nxt = prdata_r;
        slverr_nxt = slverr_r;
        if (wr) begin
            case (paddr)
                OFS_CTR_CFG: dis_nxt = pwdata[CTR_DIS_BIT];
                OFS_CLK_CFG: ccr_nxt = pwdata[5:0];
                OFS_PWR_CTRL: begin
                    pwr_nxt.sync_reset_drive = pwdata[4];
                    pwr_nxt.warm = pwr_r.warm || pwdata[1];
                    pwr_nxt.start = pwr_r.start || pwdata[0];
                end
                OFS_EARLY_THR: thr_nxt = pwdata[7:0];
                OFS_DATA: data_nxt = pwdata[0];
                OFS_IRQ_STAT: stat_nxt = stat_r & ~pwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: mask_nxt = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (start_clr) begin
            pwr_nxt.start = 1'b0;
        end
        if (warm_clr) begin
            pwr_nxt.warm = 1'b0;
        end
        stat_nxt = stat_nxt | stat_set;
        if (setup) begin
            slverr_nxt = !mapped;
            case (paddr)
                OFS_CTR_CFG: prdata_nxt = {27'h0000000, dis_r, 4'h0};
                OFS_CLK_CFG: prdata_nxt = {26'h0000000, ccr_r};
                OFS_PWR_CTRL: prdata_nxt = {27'h0000000, pwr_r.sync_reset_drive, 2'h0, pwr_r.warm, pwr_r.start};
                OFS_EARLY_THR: prdata_nxt = {24'h000000, thr_r};
                OFS_DATA: prdata_nxt = {31'h00000000, io_s2_r};
                OFS_IRQ_STAT: prdata_nxt = {30'h00000000, stat_r};
                OFS_IRQ_MASK: prdata_nxt = {30'h00000000, mask_r};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Disable bit keeps the early flag visible but off the interrupt line
    assign irq_gate = {1'b1, !dis_r};
    assign irq_nxt = |(stat_r & mask_r & irq_gate);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ccr_r <= CCR_RST;
            pwr_r <= PWR_RST;
            thr_r <= THR_RST;
            dis_r <= 1'b0;
            data_r <= DATA_RST;
            stat_r <= IRQ_RST;
            mask_r <= IRQ_RST;
            prdata_r <= 32'h00000000;
            slverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce) begin
            ccr_r <= ccr_nxt;
            pwr_r <= pwr_nxt;
            thr_r <= thr_nxt;
            dis_r <= dis_nxt;
            data_r <= data_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
            slverr_r <= slverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Frozen clock enable would hold an access, so pready follows it
    assign pready = ce;
    assign prdata = prdata_r;
    assign pslverr = slverr_r && psel && penable;
    assign irq = irq_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    stop_level_a: assert property ((!ccr_r.sync_card_select && ccr_r.clock_halt && !div_on) |->
        card_clk == ccr_r.clock_stop_level)
        else $error("stopped card clock not at stop level");
    sync_clock_a: assert property (ccr_r.sync_card_select |-> card_clk == ccr_r.clock_stop_level)
        else $error("sync card clock not following stop level");
    sync_io_a: assert property ((ccr_r.sync_card_select && ce) |=> card_io_oe == !$past(data_r))
        else $error("sync I/O not driven from data bit 0");
    sync_reset_a: assert property ((ccr_r.sync_card_select && ce) |=>
        card_rst == $past(pwr_r.sync_reset_drive))
        else $error("sync card reset not following drive bit");
    warm_seq_a: assert property ((seq_r == SEQ_ACTIVE && pwr_r.warm && !ccr_r.sync_card_select &&
        !session_stop && ce) |=> (seq_r == SEQ_RSTLOW) ##1 (!card_rst || !ce))
        else $error("warm request did not restart reset phase");
    start_act_a: assert property ((seq_r == SEQ_IDLE && pwr_r.start && !ccr_r.sync_card_select &&
        !session_stop && ce) |=> seq_r == SEQ_RSTLOW)
        else $error("start request did not begin activation");
    early_flag_a: assert property ((seq_r == SEQ_EARLY && io_fall && cnt_r < {8'h00, thr_r} && ce) |=>
        stat_r[IRQ_EARLY_BIT])
        else $error("early answer not flagged");
    irq_gate_a: assert property ((ce && dis_r && !(stat_r[IRQ_DONE_BIT] && mask_r[IRQ_DONE_BIT])) |=> !irq)
        else $error("interrupt raised while counter interrupt disabled");
    zero_write_a: assert property ((wr && paddr == OFS_PWR_CTRL && !pwdata[0] && pwr_r.start &&
        seq_r == SEQ_RSTLOW && !session_stop && ce) |=> pwr_r.start)
        else $error("writing zero cleared the start request");

    cover_early_c: cover property (seq_r == SEQ_EARLY && io_fall && cnt_r < {8'h00, thr_r});
    cover_active_c: cover property (seq_r == SEQ_EARLY ##1 seq_r == SEQ_ACTIVE);
    cover_warm_c: cover property (seq_r == SEQ_ACTIVE ##1 seq_r == SEQ_RSTLOW);

endmodule : sccp_ctrl

// ===== verif/sccp_card_model.sv
// Behavioural card on the clock, reset and open-drain I/O line of the slot.
// Assumes a pull-up on I/O; answers a start bit a set number of card clocks after reset rises.
`timescale 1ns/1ps
module sccp_card_model (
    input wire logic card_clk,
    input wire logic card_rst,
    input wire logic dev_oe,
    input wire logic dev_out,
    input wire logic [7:0] ans_ticks,
    output logic io_line
);
    int cnt;
    logic pull;
    initial begin
        cnt = 0;
        pull = 1'b0;
    end
    // Count card clocks after reset release, then pull I/O low for a start bit
    always @(posedge card_clk or negedge card_rst) begin
        if (!card_rst) begin
            cnt <= 0;
            pull <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            pull <= (cnt >= int'(ans_ticks)) && (cnt < int'(ans_ticks) + 8);
        end
    end
    // Wired-AND with pull-up: released line reads high, never a stale value
    assign io_line = !((dev_oe && !dev_out) || pull);
endmodule : sccp_card_model

// ===== verif/sccp_ctrl_tb.sv
// Self-checking bench for the smart-card clock, session and early-answer slot.
// Assumes the card model on the pins and an APB master driven from here.
`timescale 1ns/1ps
module sccp_ctrl_tb;
    import sccp_pkg::*;
    logic sys_clk, srst, ce, psel, penable, pwrite, pready, pslverr, irq, card_clk, card_rst, e;
    logic card_io_in, card_io_out, card_io_oe, uart_io_out, uart_io_oe, session_stop, io_rx, card_tick;
    logic session_active;
    logic [7:0] paddr, ans;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] c, pc;
    int failures, n_tests, g, t, i, lv;
    int cyc = 0;

    sccp_ctrl i_sccp_ctrl (.sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .card_clk(card_clk), .card_rst(card_rst),
        .card_io_in(card_io_in), .card_io_out(card_io_out), .card_io_oe(card_io_oe),
        .uart_io_out(uart_io_out), .uart_io_oe(uart_io_oe), .session_stop(session_stop),
        .io_rx(io_rx), .card_tick(card_tick), .session_active(session_active));
    sccp_card_model i_sccp_card_model (.card_clk(card_clk), .card_rst(card_rst), .dev_oe(card_io_oe),
        .dev_out(card_io_out), .ans_ticks(ans), .io_line(card_io_in));

    // 40 MHz module clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Cycles per card clock period, worked out independently of the design
    function automatic int per(input logic [2:0] k);
        if (k == 3'h6) return 8;
        if (k == 3'h7) return 16;
        return int'(k) + 1;
    endfunction : per

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; waits on pready for as long as it takes, only the hang guard ends a stall
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge sys_clk);
            g++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_n

    // Cycles to the next card clock period start
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (card_tick !== 1'b1 && n < 40);
    endtask : tick_gap

    task automatic stop_session();
        @(posedge sys_clk);
        session_stop <= 1'b1;
        @(posedge sys_clk);
        session_stop <= 1'b0;
        wait_n(3);
        chk(32'(session_active), 32'h0);
    endtask : stop_session

    // Async activation with threshold th and card answer after an card clocks
    task automatic activate(input int th, input int an, input logic early);
        ans <= 8'(an);
        apb(1'b1, OFS_EARLY_THR, 32'(th));
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        apb(1'b1, OFS_PWR_CTRL, 32'h1);
        // A zero written during the reset-low phase must leave the start request standing
        apb(1'b1, OFS_PWR_CTRL, 32'h0);
        apb(1'b0, OFS_PWR_CTRL, 32'h0);
        chk(32'(q[0]), 32'h1);
        t = 0;
        do begin
            apb(1'b0, OFS_IRQ_STAT, 32'h0);
            t++;
        end while (q[IRQ_DONE_BIT] !== 1'b1 && t < 400);
        chk(q, {30'h0, 1'b1, early});
        chk(32'(card_rst), 32'h1);
    endtask : activate

    task automatic tally_and_finish();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        {psel, penable, pwrite, session_stop, uart_io_oe} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        ce = 1'b1;
        uart_io_out = 1'b1;
        ans = 8'hFF;
        failures = 0;
        n_tests = 0;
        pc = 3'h0;
        srst = 1'b1;
        t = $urandom(32'h83c3d34f);
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset values, reserved and unmapped places
        apb(1'b0, OFS_CLK_CFG, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, OFS_PWR_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        t = $urandom % 256;
        apb(1'b1, OFS_EARLY_THR, 32'(t));
        apb(1'b0, OFS_EARLY_THR, 32'h0);
        chk(q, 32'(t));
        apb(1'b1, OFS_PWR_CTRL, 32'h0);
        wait_n(3);
        chk(32'(session_active), 32'h0);
        // Every divider code, then random changes on the fly
        for (i = 0; i < 14; i++) begin
            c = (i < 8) ? 3'(i) : 3'($urandom % 8);
            apb(1'b1, OFS_CLK_CFG, {29'h0, c});
            tick_gap(g);
            tick_gap(g);
            chk(32'(g == per(pc) || g == per(c)), 32'h1);
            tick_gap(g);
            tick_gap(g);
            chk(32'(g), 32'(per(c)));
            pc = c;
        end
        // Halted clock parks at the stop level, then sync mode follows the bits
        for (lv = 0; lv < 2; lv++) begin
            apb(1'b1, OFS_CLK_CFG, 32'h17 | 32'(lv << 5));
            wait_n(40);
            chk(32'(card_clk), 32'(lv));
            wait_n(7);
            chk(32'(card_clk), 32'(lv));
            apb(1'b1, OFS_CLK_CFG, 32'h08 | 32'(lv << 5));
            apb(1'b1, OFS_PWR_CTRL, 32'(lv << 4));
            apb(1'b1, OFS_DATA, 32'(lv));
            wait_n(3);
            chk(32'(card_clk), 32'(lv));
            chk(32'(card_rst), 32'(lv));
            chk(32'(card_io_oe), 32'(1 - lv));
            wait_n(3);
            apb(1'b0, OFS_DATA, 32'h0);
            chk(32'(q[0]), 32'(lv));
        end
        apb(1'b1, OFS_PWR_CTRL, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(32'(q[IRQ_DONE_BIT]), 32'h1);
        chk(32'(session_active), 32'h1);
        stop_session();
        apb(1'b1, OFS_CLK_CFG, 32'h0);
        // Early answer with interrupt, then with it disabled, then a late answer and a warm reset
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        t = 10 + $urandom % 50;
        activate(t, t - 6, 1'b1);
        chk(32'(irq), 32'h1);
        stop_session();
        apb(1'b1, OFS_CTR_CFG, 32'h10);
        activate(t, t - 6, 1'b1);
        chk(32'(irq), 32'h0);
        stop_session();
        apb(1'b1, OFS_CTR_CFG, 32'h0);
        activate(t, t + 12, 1'b0);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFS_PWR_CTRL, 32'h2);
        wait_n(3);
        chk(32'(card_rst), 32'h0);
        g = 0;
        while (card_rst !== 1'b1 && g < 1000) begin
            @(negedge sys_clk);
            g++;
        end
        chk(32'(card_rst), 32'h1);
        // Clock enable low freezes the sequencer even against a stop request
        @(posedge sys_clk);
        ce <= 1'b0;
        session_stop <= 1'b1;
        wait_n(3);
        chk(32'(session_active), 32'h1);
        @(posedge sys_clk);
        ce <= 1'b1;
        session_stop <= 1'b0;
        stop_session();
        // Async mode hands the pin to the character engine and returns the synced level
        @(posedge sys_clk);
        uart_io_out <= 1'b0;
        uart_io_oe <= 1'b1;
        wait_n(4);
        chk(32'(card_io_oe), 32'h1);
        chk(32'(card_io_out), 32'h0);
        chk(32'(io_rx), 32'h0);
        @(posedge sys_clk);
        uart_io_oe <= 1'b0;
        wait_n(4);
        chk(32'(io_rx), 32'h1);
        tally_and_finish();
    end
endmodule : sccp_ctrl_tb
